//--- hdl/tmr_defines.svh
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH

`define TMR_ADDR_PORT_DIR   16'hff20
`define TMR_ADDR_PRESCALE   16'hffbb
`define TMR_ADDR_CAPCOMP    16'hffbc
`define TMR_ADDR_OUTCTL     16'hffbd
`define TMR_ADDR_MODE       16'hffba
`define TMR_ADDR_CNT_LO     16'hffb0
`define TMR_ADDR_CNT_HI     16'hffb1
`define TMR_ADDR_CR0_LO     16'hffb2
`define TMR_ADDR_CR0_HI     16'hffb3
`define TMR_ADDR_CR1_LO     16'hffb4
`define TMR_ADDR_CR1_HI     16'hffb5

`define TMR_RST_PORT_DIR    4'hf
`define TMR_RST_BYTE        8'h00

`define TMR_OC_OSPT         6
`define TMR_OC_OSPE         5
`define TMR_OC_T2EN         4
`define TMR_OC_LVS          3
`define TMR_OC_LVR          2
`define TMR_OC_T1EN         1
`define TMR_OC_TOE          0

`define TMR_CC_MODE2        2
`define TMR_CC_TRIG1        1
`define TMR_CC_MODE1        0

`define TMR_DIV4_MASK       8'h03
`define TMR_DIV256_MASK     8'hff

`endif

//--- hdl/tmr_edge.sv
`timescale 1ns/1ps
`default_nettype none
module tmr_edge
    import tmr_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             pin,
    input  wire logic             track,
    input  wire logic             run,
    input  wire tmr_pkg::tmr_edge_t sel,
    output logic                  rise,
    output logic                  fall,
    output logic                  valid
);
    logic sync1;
    logic sync2;
    logic prev;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
        end
        else
        begin
            sync1 <= pin;
            sync2 <= sync1;
        end
    end

    // Previous level starts low and only tracks once counting was first enabled
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            prev <= 1'b0;
        else if (track)
            prev <= sync2;
    end

    // Edge pulses, only while the counter runs
    always_comb
    begin
        rise  = run && sync2 && !prev;
        fall  = run && !sync2 && prev;
        valid = 1'b0;
        unique case (sel)
            TMR_EDGE_FALL: valid = fall;
            TMR_EDGE_RISE: valid = rise;
            TMR_EDGE_BOTH: valid = rise || fall;
            TMR_EDGE_NONE: valid = 1'b0;
        endcase
    end

    AST_EDGE_PROHIBITED: assert property (@(posedge clk) disable iff (rst)
        (sel == TMR_EDGE_NONE) |-> !valid)
        else $error("Prohibited edge code produced an edge");
    AST_EDGE_RISE_SEL: assert property (@(posedge clk) disable iff (rst)
        (sel == TMR_EDGE_RISE && run && sync2 && !$past(sync2) && $past(track)) |-> valid)
        else $error("Rising edge not reported");
endmodule
`default_nettype wire

//--- hdl/tmr_out_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tmr_out_if;
    logic       toc_wr;
    logic [7:0] wdata;
    logic       match0;
    logic       match1;
    logic       shot_ok;
    logic       sw_trig;
    logic       oneshot_en;
    logic [7:0] toc_rdata;

    modport ctl (output toc_wr, output wdata, output match0, output match1, output shot_ok,
                 input sw_trig, input oneshot_en, input toc_rdata);
    modport out (input toc_wr, input wdata, input match0, input match1, input shot_ok,
                 output sw_trig, output oneshot_en, output toc_rdata);
endinterface
`default_nettype wire

//--- hdl/tmr_outctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.svh"
module tmr_outctl
    import tmr_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    tmr_out_if.out    oif,
    output logic      pin
);
    logic ospe;
    logic t2en;
    logic t1en;
    logic toe;
    logic ff;
    logic sw_trig;

    // Control bits; only the second-match enable is meant to change while counting
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ospe <= 1'b0;
            t2en <= 1'b0;
            t1en <= 1'b0;
            toe  <= 1'b0;
        end
        else if (oif.toc_wr)
        begin
            ospe <= oif.wdata[`TMR_OC_OSPE];
            t2en <= oif.wdata[`TMR_OC_T2EN];
            t1en <= oif.wdata[`TMR_OC_T1EN];
            toe  <= oif.wdata[`TMR_OC_TOE];
        end
    end

    // Software trigger is a one-cycle pulse, never stored
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            sw_trig <= 1'b0;
        else
            sw_trig <= oif.toc_wr && oif.wdata[`TMR_OC_OSPT];
    end

    // Output flip-flop: direct set/clear wins over match toggling
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ff <= 1'b0;
        else if (oif.toc_wr && oif.wdata[`TMR_OC_LVS -: 2] == 2'h1)
            ff <= 1'b0;
        else if (oif.toc_wr && oif.wdata[`TMR_OC_LVS -: 2] == 2'h2)
            ff <= 1'b1;
        else if (oif.shot_ok)
            ff <= ff ^ (oif.match0 && t1en) ^ (oif.match1 && t2en);
    end

    // Pin follows flip-flop only when enabled
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pin <= 1'b0;
        else
            pin <= toe && ff;
    end

    assign oif.sw_trig    = sw_trig;
    assign oif.oneshot_en = ospe;
    // Trigger and level bits read back as zero
    assign oif.toc_rdata  = {2'h0, ospe, t2en, 2'h0, t1en, toe};

    AST_PIN_DISABLED: assert property (@(posedge clk) disable iff (rst)
        !toe |=> !pin)
        else $error("Pin not low while output disabled");
    AST_LEVEL_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (oif.toc_wr && oif.wdata[3:2] == 2'h1) |=> !ff ##1 !pin)
        else $error("Level clear did not reset flip-flop");
    AST_LEVEL_SET: assert property (@(posedge clk) disable iff (rst)
        (oif.toc_wr && oif.wdata[3:2] == 2'h2) |=> ff)
        else $error("Level set did not set flip-flop");
    AST_TOGGLE_SECOND: assert property (@(posedge clk) disable iff (rst)
        (!oif.toc_wr && oif.shot_ok && oif.match1 && t2en && !oif.match0) |=> (ff != $past(ff)))
        else $error("Second match did not toggle");
    AST_NO_TOGGLE: assert property (@(posedge clk) disable iff (rst)
        (!oif.toc_wr && !(oif.match0 && t1en) && !(oif.match1 && t2en)) |=> $stable(ff))
        else $error("Flip-flop changed without cause");
endmodule
`default_nettype wire

//--- hdl/tmr_pkg.sv
package tmr_pkg;
    typedef enum logic [1:0] {
        TMR_EDGE_FALL = 2'h0,
        TMR_EDGE_RISE = 2'h1,
        TMR_EDGE_NONE = 2'h2,
        TMR_EDGE_BOTH = 2'h3
    } tmr_edge_t;

    typedef enum logic [1:0] {
        TMR_CLK_SYS    = 2'h0,
        TMR_CLK_DIV4   = 2'h1,
        TMR_CLK_DIV256 = 2'h2,
        TMR_CLK_PIN    = 2'h3
    } tmr_clk_sel_t;

    typedef enum logic [1:0] {
        TMR_OP_STOP     = 2'h0,
        TMR_OP_FREE     = 2'h1,
        TMR_OP_EDGE_CLR = 2'h2,
        TMR_OP_MATCH_CLR = 2'h3
    } tmr_opmode_t;

    typedef enum logic [2:0] {
        TMR_ST_NEVER   = 3'h1,
        TMR_ST_RUN     = 3'h2,
        TMR_ST_STOPPED = 3'h4
    } tmr_run_t;
endpackage

//--- hdl/tmr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defines.svh"
module tmr_top
    import tmr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] addr,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata,
    input  wire logic        timer_input_a,
    input  wire logic        timer_input_b,
    output logic             timer_output_pin,
    output logic             timer_output_oe,
    output logic      [3:0]  port0_dir,
    output logic             first_match_irq,
    output logic             second_match_irq
);
    tmr_out_if oif ();

    logic [3:0]   pm0;
    logic [7:0]   prm;
    logic [2:0]   crc;
    tmr_opmode_t  opmode;
    logic         tmc_out_timing;
    logic         ovf;
    logic [15:0]  cnt;
    logic [15:0]  first_capcomp_reg;
    logic [15:0]  second_capcomp_reg;
    logic [7:0]   pre;
    tmr_run_t     run_state;
    logic         running;
    logic         shot;
    logic         tick;
    logic         a_rise;
    logic         a_fall;
    logic         a_valid;
    logic         b_valid;
    logic         cap0;
    logic         cap1;
    logic         match0;
    logic         match1;
    logic         trig;
    logic         clr_edge;
    logic [15:0]  next_cnt;
    tmr_edge_t    a_sel;
    tmr_edge_t    b_sel;
    tmr_clk_sel_t clk_sel;

    assign a_sel   = tmr_edge_t'(prm[5:4]);
    assign b_sel   = tmr_edge_t'(prm[7:6]);
    assign clk_sel = tmr_clk_sel_t'(prm[1:0]);
    assign running = (opmode != TMR_OP_STOP);

    // Valid-edge detection for both inputs
    tmr_edge u_edge_a (
        .clk   (clk),
        .rst   (rst),
        .pin   (timer_input_a),
        .track (run_state != TMR_ST_NEVER),
        .run   (running),
        .sel   (a_sel),
        .rise  (a_rise),
        .fall  (a_fall),
        .valid (a_valid)
    );

    tmr_edge u_edge_b (
        .clk   (clk),
        .rst   (rst),
        .pin   (timer_input_b),
        .track (run_state != TMR_ST_NEVER),
        .run   (running),
        .sel   (b_sel),
        .rise  (),
        .fall  (),
        .valid (b_valid)
    );

    // Output flip-flop and its control register
    tmr_outctl u_outctl (
        .clk (clk),
        .rst (rst),
        .oif (oif.out),
        .pin (timer_output_pin)
    );

    // Remembers whether counting was ever enabled, so restarts see no stale edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            run_state <= TMR_ST_NEVER;
        else
        begin
            unique case (run_state)
                TMR_ST_NEVER:   run_state <= running ? TMR_ST_RUN : TMR_ST_NEVER;
                TMR_ST_RUN:     run_state <= running ? TMR_ST_RUN : TMR_ST_STOPPED;
                TMR_ST_STOPPED: run_state <= running ? TMR_ST_RUN : TMR_ST_STOPPED;
                default:        run_state <= TMR_ST_NEVER;
            endcase
        end
    end

    // Register writes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pm0            <= `TMR_RST_PORT_DIR;
            prm            <= `TMR_RST_BYTE;
            crc            <= 3'h0;
            opmode         <= TMR_OP_STOP;
            tmc_out_timing <= 1'b0;
        end
        else if (wr)
        begin
            unique case (addr)
                `TMR_ADDR_PORT_DIR: pm0 <= wdata[3:0];
                `TMR_ADDR_PRESCALE: prm <= wdata;
                `TMR_ADDR_CAPCOMP:  crc <= wdata[2:0];
                `TMR_ADDR_MODE:
                begin
                    opmode         <= tmr_opmode_t'(wdata[3:2]);
                    tmc_out_timing <= wdata[1];
                end
                default: ;
            endcase
        end
    end

    assign port0_dir       = pm0;
    assign timer_output_oe = !pm0[1];

    // Prescaler for the divided count clocks
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            pre <= 8'h00;
        else if (!running)
            pre <= 8'h00;
        else
            pre <= pre + 8'h01;
    end

    // Count clock selection
    always_comb
    begin
        tick = 1'b0;
        unique case (clk_sel)
            TMR_CLK_SYS:    tick = running;
            TMR_CLK_DIV4:   tick = running && ((pre & `TMR_DIV4_MASK) == `TMR_DIV4_MASK);
            TMR_CLK_DIV256: tick = running && (pre == `TMR_DIV256_MASK);
            TMR_CLK_PIN:    tick = a_valid;
        endcase
    end

    // Capture triggers per register mode and trigger selection
    always_comb
    begin
        cap1 = crc[`TMR_CC_MODE2] && a_valid;
        cap0 = 1'b0;
        if (crc[`TMR_CC_MODE1])
        begin
            if (!crc[`TMR_CC_TRIG1])
                cap0 = b_valid;
            else if (a_sel == TMR_EDGE_FALL)
                cap0 = a_rise;
            else if (a_sel == TMR_EDGE_RISE)
                cap0 = a_fall;
            else
                cap0 = 1'b0;
        end
    end

    // Compare matches only while the register works as a compare register
    assign match0 = tick && !crc[`TMR_CC_MODE1] && (cnt == first_capcomp_reg);
    assign match1 = tick && !crc[`TMR_CC_MODE2] && (cnt == second_capcomp_reg);

    // One-shot trigger only in free-running or edge-clear mode
    assign trig = oif.oneshot_en && (opmode == TMR_OP_FREE || opmode == TMR_OP_EDGE_CLR)
                  && (oif.sw_trig || (opmode == TMR_OP_EDGE_CLR && a_valid));
    assign clr_edge = (opmode == TMR_OP_EDGE_CLR) && a_valid;

    // One-shot window from trigger until first-register match
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            shot <= 1'b0;
        else if (!running)
            shot <= 1'b0;
        else if (trig)
            shot <= 1'b1;
        else if (match0)
            shot <= 1'b0;
    end

    assign oif.toc_wr  = wr && (addr == `TMR_ADDR_OUTCTL);
    assign oif.wdata   = wdata;
    assign oif.match0  = match0;
    assign oif.match1  = match1;
    assign oif.shot_ok = !oif.oneshot_en || shot || trig;

    // Next counter value
    always_comb
    begin
        next_cnt = cnt;
        if (!running)
            next_cnt = 16'h0000;
        else if (trig || clr_edge)
            next_cnt = 16'h0000;
        else if (tick && opmode == TMR_OP_MATCH_CLR && cnt == first_capcomp_reg)
            next_cnt = 16'h0000;
        else if (tick)
            next_cnt = cnt + 16'h0001;
    end

    // Counter
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt <= 16'h0000;
        else
            cnt <= next_cnt;
    end

    // Overflow flag; the hardware set wins over a software clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ovf <= 1'b0;
        else if (tick && cnt == 16'hffff && next_cnt == 16'h0000)
            ovf <= 1'b1;
        else if (wr && addr == `TMR_ADDR_MODE)
            ovf <= wdata[0];
    end

    // Capture/compare registers: capture wins over a software write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            first_capcomp_reg  <= 16'h0000;
            second_capcomp_reg <= 16'h0000;
        end
        else
        begin
            if (cap0)
                first_capcomp_reg <= cnt;
            else if (wr && addr == `TMR_ADDR_CR0_LO)
                first_capcomp_reg[7:0] <= wdata;
            else if (wr && addr == `TMR_ADDR_CR0_HI)
                first_capcomp_reg[15:8] <= wdata;
            if (cap1)
                second_capcomp_reg <= cnt;
            else if (wr && addr == `TMR_ADDR_CR1_LO)
                second_capcomp_reg[7:0] <= wdata;
            else if (wr && addr == `TMR_ADDR_CR1_HI)
                second_capcomp_reg[15:8] <= wdata;
        end
    end

    // Request pulses on match or capture
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            first_match_irq  <= 1'b0;
            second_match_irq <= 1'b0;
        end
        else
        begin
            first_match_irq  <= match0 || cap0;
            second_match_irq <= match1 || cap1;
        end
    end

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (rd)
        begin
            unique case (addr)
                `TMR_ADDR_PORT_DIR: rdata <= {4'hf, pm0};
                `TMR_ADDR_PRESCALE: rdata <= {prm[7:4], 2'h0, prm[1:0]};
                `TMR_ADDR_CAPCOMP:  rdata <= {5'h00, crc};
                `TMR_ADDR_OUTCTL:   rdata <= oif.toc_rdata;
                `TMR_ADDR_MODE:     rdata <= {4'h0, opmode, tmc_out_timing, ovf};
                `TMR_ADDR_CNT_LO:   rdata <= cnt[7:0];
                `TMR_ADDR_CNT_HI:   rdata <= cnt[15:8];
                `TMR_ADDR_CR0_LO:   rdata <= first_capcomp_reg[7:0];
                `TMR_ADDR_CR0_HI:   rdata <= first_capcomp_reg[15:8];
                `TMR_ADDR_CR1_LO:   rdata <= second_capcomp_reg[7:0];
                `TMR_ADDR_CR1_HI:   rdata <= second_capcomp_reg[15:8];
                default:            rdata <= 8'h00;
            endcase
        end
    end

    AST_TRIGGER_READS_ZERO: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == `TMR_ADDR_OUTCTL) |=> (rdata[6] == 1'b0))
        else $error("One-shot trigger bit read as one");
    AST_LEVEL_READS_ZERO: assert property (@(posedge clk) disable iff (rst)
        (rd && addr == `TMR_ADDR_OUTCTL) |=> (rdata[3:2] == 2'h0))
        else $error("Level bits read as nonzero");
    AST_CAPTURE_SECOND: assert property (@(posedge clk) disable iff (rst)
        cap1 |=> ((second_capcomp_reg == $past(cnt)) && second_match_irq))
        else $error("Second register did not capture counter");
    AST_COMPARE_HOLDS: assert property (@(posedge clk) disable iff (rst)
        (!crc[0] && !(wr && (addr == `TMR_ADDR_CR0_LO || addr == `TMR_ADDR_CR0_HI)))
        |=> $stable(first_capcomp_reg))
        else $error("Compare register changed without a write");
    AST_NO_OPPOSITE_BOTH: assert property (@(posedge clk) disable iff (rst)
        (crc[1] && a_sel == TMR_EDGE_BOTH) |-> !cap0)
        else $error("Opposite-phase capture with both edges selected");
    AST_INTERVAL_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (opmode == TMR_OP_MATCH_CLR && match0 && !trig && !clr_edge) |=> (cnt == 16'h0000) && first_match_irq)
        else $error("Interval match did not clear counter and request");
    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (rst)
        (tick && !trig && !clr_edge && opmode == TMR_OP_FREE) |=> (cnt == $past(cnt) + 16'h0001))
        else $error("Counter did not step on count event");
    AST_PORT_DIR_RESET: assert property (@(posedge clk)
        $fell(rst) |-> (port0_dir == 4'hf))
        else $error("Port direction not all ones after reset");
endmodule
`default_nettype wire

//--- test/timer16_capture_compare_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_compare_ctrl_tb;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [15:0] addr  = 16'h0000;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic        rd_d  = 1'b0;
    logic [31:0] seed  = 32'h8aab;
    logic [7:0]  exp_q[$];
    int          failures = 0;
    int          checks   = 0;
    int          cycles   = 0;
    wire logic [7:0] rdata;
    wire logic [3:0] dir;
    wire logic   pin_a, pin_b, out_pin, out_oe, irq0, irq1;

    always #20 clk = ~clk;

    tmr_top i_dut (.clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .rdata(rdata),
        .timer_input_a(pin_a), .timer_input_b(pin_b), .timer_output_pin(out_pin),
        .timer_output_oe(out_oe), .port0_dir(dir), .first_match_irq(irq0), .second_match_irq(irq1));
    tmr_pins_model i_pins (.clk(clk), .pin_a(pin_a), .pin_b(pin_b));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Notes the expected answer, then issues the read
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // Cycles from one first-match pulse to the next
    task automatic wait_irq(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (irq0 !== 1'b1 && n < 200);
    endtask

    // Read answers against the oldest note, plus the hang limit
    always @(posedge clk)
    begin
        cycles++;
        if (rd_d)
            check(rdata, exp_q.pop_front());
        rd_d <= rd;
        if (cycles == 20000)
        begin
            failures++;
            give_verdict();
        end
    end

    // Main sequence
    initial
    begin
        int n;
        int m;
        int c;
        int d;
        logic p0;
        static logic [7:0] tocs[3] = '{8'h01, 8'h03, 8'h11};
        static logic [7:0] prm[3]  = '{8'h40, 8'h30, 8'h10};
        static logic [7:0] crc[3]  = '{8'h01, 8'h03, 8'h07};
        static int exp_c[3]        = '{1, 0, 1};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(16'hff20, 8'hff);
        rd_reg(16'hffbb, 8'h00);
        rd_reg(16'hffbd, 8'h00);
        rd_reg(16'hff00, 8'h00);
        check(dir, 4'hf);
        wr_reg(16'hffbc, 8'hff);
        rd_reg(16'hffbc, 8'h07);
        wr_reg(16'hffbc, 8'h00);
        wr_reg(16'hffbd, 8'h65);
        rd_reg(16'hffbd, 8'h21);
        wr_reg(16'hffbd, 8'h00);
        $display("test registers done");
        for (int k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            wr_reg(16'hff20, seed[7:0]);
            wr_reg(16'hffb4, seed[15:8]);
            rd_reg(16'hff20, {4'hf, seed[3:0]});
            rd_reg(16'hffb4, seed[15:8]);
            tick(2);
            check(out_oe, !seed[1]);
        end
        wr_reg(16'hff20, 8'hfd);
        $display("test random done");
        wr_reg(16'hffbd, 8'h01);
        wr_reg(16'hffbd, 8'h09);
        tick(3);
        check(out_pin, 1'b1);
        wr_reg(16'hffbd, 8'h05);
        tick(3);
        check(out_pin, 1'b0);
        wr_reg(16'hffbd, 8'h09);
        wr_reg(16'hffbd, 8'h00);
        tick(3);
        check(out_pin, 1'b0);
        $display("test level done");
        for (int k = 0; k < 3; k++)
        begin
            seed = xs(seed);
            n = 4 + int'(seed[2:0]);
            d = (k == 1) ? 4 : 1;
            wr_reg(16'hffba, 8'h00);
            wr_reg(16'hffbb, (k == 1) ? 8'h01 : 8'h00);
            wr_reg(16'hffb2, 8'(n));
            wr_reg(16'hffb3, 8'h00);
            wr_reg(16'hffb4, 8'h01);
            wr_reg(16'hffb5, 8'h00);
            wr_reg(16'hffbd, tocs[k]);
            wr_reg(16'hffba, 8'h0c);
            wait_irq(m);
            wait_irq(m);
            check(16'(m), 16'(d * (n + 1)));
            tick(4);
            p0 = out_pin;
            c = 0;
            repeat (d * (n + 1))
            begin
                @(posedge clk);
                c = c + int'(irq1);
            end
            check(16'(c), 16'h0001);
            check(out_pin, (tocs[k] == 8'h01) ? p0 : !p0);
        end
        $display("test interval done");
        for (int k = 0; k < 3; k++)
        begin
            wr_reg(16'hffba, 8'h00);
            wr_reg(16'hffbd, 8'h00);
            wr_reg(16'hffbc, crc[k]);
            wr_reg(16'hffbb, prm[k]);
            wr_reg(16'hffba, 8'h04);
            tick(4);
            c = 0;
            fork
                i_pins.pulse(k == 0, 6);
                repeat (30)
                begin
                    @(posedge clk);
                    if (irq0 === 1'b1)
                        c++;
                end
            join
            check(16'(c), 16'(exp_c[k]));
        end
        $display("test capture done");
        // Input A rising edges as the count clock
        wr_reg(16'hffba, 8'h00);
        wr_reg(16'hffbc, 8'h00);
        wr_reg(16'hffbb, 8'h13);
        wr_reg(16'hffba, 8'h04);
        tick(4);
        repeat (2)
        begin
            i_pins.pulse(1'b0, 6);
            tick(4);
        end
        rd_reg(16'hffb0, 8'h02);
        $display("test pin clock done");
        // One-shot: no toggle before the trigger, exactly one after it
        wr_reg(16'hffba, 8'h00);
        wr_reg(16'hffbb, 8'h00);
        wr_reg(16'hffb2, 8'h05);
        wr_reg(16'hffbd, 8'h27);
        wr_reg(16'hffba, 8'h04);
        tick(20);
        check(out_pin, 1'b0);
        wr_reg(16'hffbd, 8'h63);
        tick(20);
        check(out_pin, 1'b1);
        tick(20);
        check(out_pin, 1'b1);
        $display("test one-shot done");
        tick(3);
        give_verdict();
    end
endmodule
`default_nettype wire

//--- test/tmr_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// Drives the two external timer input pins
module tmr_pins_model (
    input  wire logic clk,
    output logic      pin_a,
    output logic      pin_b
);
    // Both pins idle low
    initial
    begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // High pulse kept well over two count clocks
    task automatic pulse(input bit sel_b, input int width);
        @(posedge clk);
        if (sel_b)
            pin_b <= 1'b1;
        else
            pin_a <= 1'b1;
        repeat (width) @(posedge clk);
        pin_a <= 1'b0;
        pin_b <= 1'b0;
    endtask
endmodule
`default_nettype wire
